// ===== ppm_port_mux.sv
// Port pin function mux with APB register access
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "ppm_params.svh"
module ppm_port_mux (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`PPM_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Pin inputs
   input  wire logic                   p17_pin_i,
   input  wire logic                   p14_pin_i,
   input  wire logic                   p50_pin_i,
   input  wire logic                   p75_pin_i,
   input  wire logic                   p74_pin_i,
   // Pin outputs and active-low enables
   output logic                        p17_pin_o,
   output logic                        p17_pin_oe_n,
   output logic                        p14_pin_o,
   output logic                        p14_pin_oe_n,
   output logic                        p22_pin_o,
   output logic                        p22_pin_oe_n,
   output logic                        p72_pin_o,
   output logic                        p72_pin_oe_n,
   output logic                        p50_pin_o,
   output logic                        p50_pin_oe_n,
   output logic                        p76_pin_o,
   output logic                        p76_pin_oe_n,
   // Peripheral side
   input  wire logic                   serial1_txd,
   input  wire logic                   serial2_txd,
   input  wire logic                   timer8_out_en,
   input  wire logic                   timer8_output,
   output logic                        input_a,
   output logic                        input_b,
   output logic                        wakeup_input_0,
   output logic                        timer8_clock_input,
   output logic                        timer8_reset_input
);
   import ppm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   ppm_byte_t fsel_q;          // Port function select 1
   ppm_byte_t p5sel_q;         // Port 5 function select
   ppm_byte_t p5dir_q;         // Port 5 direction
   ppm_byte_t p7dir_q;         // Port 7 direction
   ppm_byte_t p7out_q;         // Port 7 output data
   ppm_gpio_t gdir_q;          // p17/p14/p22 direction
   ppm_gpio_t gout_q;          // p17/p14/p22 output data

   // Read data mux helper, used for every mapped read
   function automatic logic [31:0] ppm_word(input ppm_byte_t v);
      ppm_word = {24'h00_0000, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   wire acc      = psel & penable;
   wire wr       = acc & pwrite;
   wire hit_fsel = paddr == `PPM_OFF_FSEL1;
   wire hit_p5s  = paddr == `PPM_OFF_P5SEL;
   wire hit_p5d  = paddr == `PPM_OFF_P5DIR;
   wire hit_p7d  = paddr == `PPM_OFF_P7DIR;
   wire hit_p7o  = paddr == `PPM_OFF_P7OUT;
   wire hit_gd   = paddr == `PPM_OFF_GPIO_DIR;
   wire hit_go   = paddr == `PPM_OFF_GPIO_OUT;
   wire hit_pin  = paddr == `PPM_OFF_PIN_IN;
   wire hit_any  = hit_fsel | hit_p5s | hit_p5d | hit_p7d | hit_p7o | hit_gd | hit_go | hit_pin;

   // Live pin levels for readback
   wire [7:0] pin_lvl = {p17_pin_i, p14_pin_i, p50_pin_i, p75_pin_i, p74_pin_i, 3'h0};

   // Read data selection; reserved bits other than bit 2 are masked at write so read as zero
   logic [31:0] rd_sel;
   always_comb begin
      if (hit_fsel)     rd_sel = ppm_word(fsel_q);
      else if (hit_p5s) rd_sel = ppm_word(p5sel_q);
      else if (hit_p5d) rd_sel = ppm_word(p5dir_q);
      else if (hit_p7d) rd_sel = ppm_word(p7dir_q);
      else if (hit_p7o) rd_sel = ppm_word(p7out_q);
      else if (hit_gd)  rd_sel = ppm_word({5'h00, gdir_q});
      else if (hit_go)  rd_sel = ppm_word({5'h00, gout_q});
      else if (hit_pin) rd_sel = ppm_word(pin_lvl);
      else              rd_sel = `PPM_WORD_ZERO;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; bit 2 is stored as written, software keeps it 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel_q  <= `PPM_FSEL1_RESET;
         p5sel_q <= `PPM_REG_ZERO;
         p5dir_q <= `PPM_REG_ZERO;
         p7dir_q <= `PPM_REG_ZERO;
         p7out_q <= `PPM_REG_ZERO;
         gdir_q  <= `PPM_GPIO_RESET;
         gout_q  <= `PPM_GPIO_RESET;
      end else if (wr) begin
         if (hit_fsel) fsel_q  <= pwdata[7:0] & `PPM_FSEL1_MASK;
         if (hit_p5s)  p5sel_q <= pwdata[7:0];
         if (hit_p5d)  p5dir_q <= pwdata[7:0];
         if (hit_p7d)  p7dir_q <= pwdata[7:0];
         if (hit_p7o)  p7out_q <= pwdata[7:0];
         if (hit_gd)   gdir_q  <= pwdata[2:0];
         if (hit_go)   gout_q  <= pwdata[2:0];
      end
   end

   // APB answer: one wait state, ready in the access cycle's next edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `PPM_WORD_ZERO;
      end else begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~hit_any;
         prdata  <= (acc & ~pready & ~pwrite) ? rd_sel : `PPM_WORD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin selection
   wire s17 = fsel_q[`PPM_BIT_P17];
   wire s14 = fsel_q[`PPM_BIT_P14];
   wire s72 = fsel_q[`PPM_BIT_P72];
   wire s22 = fsel_q[`PPM_BIT_P22];
   wire swk = p5sel_q[`PPM_BIT_WAKE];
   wire s76 = timer8_out_en;

   // Combinational drives, registered below
   logic o17, e17, o14, e14, o22, e22, o72, e72, o50, e50, o76, e76;

   // Inputs functions have no output: enable held off
   ppm_pin_cell u_p17 (.sel_periph(s17), .periph_drive(1'b0), .periph_out(1'b0),
      .gpio_dir(gdir_q[`PPM_GB_P17]), .gpio_out(gout_q[`PPM_GB_P17]), .pin_out(o17), .pin_oe_n(e17));
   ppm_pin_cell u_p14 (.sel_periph(s14), .periph_drive(1'b0), .periph_out(1'b0),
      .gpio_dir(gdir_q[`PPM_GB_P14]), .gpio_out(gout_q[`PPM_GB_P14]), .pin_out(o14), .pin_oe_n(e14));
   ppm_pin_cell u_p22 (.sel_periph(s22), .periph_drive(1'b1), .periph_out(serial1_txd),
      .gpio_dir(gdir_q[`PPM_GB_P22]), .gpio_out(gout_q[`PPM_GB_P22]), .pin_out(o22), .pin_oe_n(e22));
   ppm_pin_cell u_p72 (.sel_periph(s72), .periph_drive(1'b1), .periph_out(serial2_txd),
      .gpio_dir(p7dir_q[`PPM_BIT_P72_GPIO]), .gpio_out(p7out_q[`PPM_BIT_P72_GPIO]),
      .pin_out(o72), .pin_oe_n(e72));
   ppm_pin_cell u_p50 (.sel_periph(swk), .periph_drive(1'b0), .periph_out(1'b0),
      .gpio_dir(p5dir_q[`PPM_BIT_P50]), .gpio_out(1'b0), .pin_out(o50), .pin_oe_n(e50));
   ppm_pin_cell u_p76 (.sel_periph(s76), .periph_drive(1'b1), .periph_out(timer8_output),
      .gpio_dir(p7dir_q[`PPM_BIT_P76]), .gpio_out(p7out_q[`PPM_BIT_P76]), .pin_out(o76), .pin_oe_n(e76));

   // Register every pin and peripheral output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {p17_pin_o, p14_pin_o, p22_pin_o, p72_pin_o, p50_pin_o, p76_pin_o} <= `PPM_PIN6_RESET;
         {p17_pin_oe_n, p14_pin_oe_n, p22_pin_oe_n} <= `PPM_OE3_RESET;
         {p72_pin_oe_n, p50_pin_oe_n, p76_pin_oe_n} <= `PPM_OE3_RESET;
         {input_a, input_b, wakeup_input_0} <= `PPM_FN3_RESET;
         {timer8_clock_input, timer8_reset_input} <= `PPM_FN2_RESET;
      end else begin
         {p17_pin_o, p14_pin_o, p22_pin_o, p72_pin_o, p50_pin_o, p76_pin_o} <= {o17, o14, o22, o72, o50, o76};
         {p17_pin_oe_n, p14_pin_oe_n, p22_pin_oe_n} <= {e17, e14, e22};
         {p72_pin_oe_n, p50_pin_oe_n, p76_pin_oe_n} <= {e72, e50, e76};
         input_a            <= s17 & p17_pin_i;
         input_b            <= s14 & p14_pin_i;
         wakeup_input_0     <= swk & p50_pin_i;
         timer8_clock_input <= p75_pin_i;
         timer8_reset_input <= p74_pin_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence fsel_write_s;
      psel & penable & pwrite & ~pready & (paddr == `PPM_OFF_FSEL1);
   endsequence

   reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fsel_q & ~`PPM_FSEL1_MASK) == `PPM_REG_ZERO) else $error("reserved select bits set");
   p17_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      s17 |=> p17_pin_oe_n && (input_a == $past(p17_pin_i))) else $error("p17 not input_a");
   p14_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      s14 |=> p14_pin_oe_n && (input_b == $past(p14_pin_i))) else $error("p14 not input_b");
   p72_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      s72 |=> !p72_pin_oe_n && (p72_pin_o == $past(serial2_txd))) else $error("p72 not serial2");
   p22_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      s22 |=> !p22_pin_oe_n && (p22_pin_o == $past(serial1_txd))) else $error("p22 not serial1");
   wake_over_a: assert property (@(posedge pclk) disable iff (!presetn)
      swk |=> p50_pin_oe_n) else $error("p50 driven in wake mode");
   timer_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer8_out_en |=> !p76_pin_oe_n && (p76_pin_o == $past(timer8_output))) else $error("timer lost p76");
   timer_in_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 timer8_clock_input == $past(p75_pin_i) && timer8_reset_input == $past(p74_pin_i))
      else $error("timer inputs not fed");
   gpio_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s22 |=> p22_pin_oe_n == !$past(gdir_q[`PPM_GB_P22])) else $error("p22 gpio direction");
   fsel_store_a: assert property (@(posedge pclk) disable iff (!presetn)
      fsel_write_s |=> fsel_q == ($past(pwdata[7:0]) & `PPM_FSEL1_MASK)) else $error("select write lost");

   // p17 and p76 left as general I/O follow their direction and data bits
   p17_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s17 |=> p17_pin_o == $past(gout_q[`PPM_GB_P17]) && p17_pin_oe_n == !$past(gdir_q[`PPM_GB_P17]))
      else $error("p17 gpio setting");
   p76_gpio_a: assert property (@(posedge pclk) disable iff (!presetn)
      !timer8_out_en |=> p76_pin_o == $past(p7out_q[`PPM_BIT_P76]) && p76_pin_oe_n == !$past(p7dir_q[`PPM_BIT_P76]))
      else $error("p76 gpio setting");

   // A function input must read low when not selected and follow its pin when selected
   func_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s17 |=> !input_a) else $error("input_a active in gpio mode");
   wake_in_a: assert property (@(posedge pclk) disable iff (!presetn)
      swk |=> wakeup_input_0 == $past(p50_pin_i)) else $error("p50 wake level lost");

   // Bus answer: one wait state, then a single-cycle ready pulse
   sequence apb_first_s;
      psel & penable & ~pready;
   endsequence

   apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      apb_first_s |=> pready) else $error("no ready after wait state");
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("ready held too long");
endmodule

// ===== ppm_params.svh
// Constants and register map of the port pin function mux
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_ADDR_W         12
`define PPM_OFF_FSEL1      12'h000
`define PPM_OFF_P5SEL      12'h004
`define PPM_OFF_P5DIR      12'h008
`define PPM_OFF_P7DIR      12'h00c
`define PPM_OFF_P7OUT      12'h010
`define PPM_OFF_GPIO_DIR   12'h014
`define PPM_OFF_GPIO_OUT   12'h018
`define PPM_OFF_PIN_IN     12'h01c
`define PPM_FSEL1_MASK     8'h9e
`define PPM_FSEL1_RESET    8'h00
`define PPM_BIT_P17        7
`define PPM_BIT_P14        4
`define PPM_BIT_P72        3
`define PPM_BIT_RSV2       2
`define PPM_BIT_P22        1
`define PPM_BIT_WAKE       0
`define PPM_BIT_P50        0
`define PPM_BIT_P76        6
`define PPM_BIT_P75        5
`define PPM_BIT_P74        4
`define PPM_GB_P17         0
`define PPM_GB_P14         1
`define PPM_GB_P22         2
`define PPM_REG_ZERO       8'h00
`define PPM_WORD_ZERO      32'h0000_0000
`define PPM_BIT_P72_GPIO   2
`define PPM_GPIO_RESET     3'h0
`define PPM_PIN6_RESET     6'h00
`define PPM_OE3_RESET      3'h7
`define PPM_FN3_RESET      3'h0
`define PPM_FN2_RESET      2'h0
`endif

// ===== ppm_pkg.sv
// Types shared by the port pin function mux
package ppm_pkg;
   typedef logic [7:0] ppm_byte_t;
   typedef logic [2:0] ppm_gpio_t;
endpackage

// ===== ppm_pin_cell.sv
// One shared pin: picks between GPIO and a peripheral output
`timescale 1ns/1ns
module ppm_pin_cell (
   // Selection
   input  wire logic sel_periph,
   input  wire logic periph_drive,
   input  wire logic periph_out,
   // General I/O setting
   input  wire logic gpio_dir,
   input  wire logic gpio_out,
   // Resulting pin drive
   output logic      pin_out,
   output logic      pin_oe_n
);
   // Peripheral owns the pin when selected; else direction/data bits
   assign pin_out  = sel_periph ? periph_out : gpio_out;
   assign pin_oe_n = sel_periph ? ~periph_drive : ~gpio_dir;
endmodule

// ===== ppm_port_mux_test.sv
// Self-checking testbench for the port pin function mux
`timescale 1ns/1ns
`include "ppm_params.svh"
module ppm_port_mux_test;
   import ppm_pkg::*;
   // Clock, reset and APB master
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   // Pin inputs and outputs
   logic        p17_pin_i, p14_pin_i, p50_pin_i, p75_pin_i, p74_pin_i;
   logic        p17_pin_o, p17_pin_oe_n, p14_pin_o, p14_pin_oe_n, p22_pin_o, p22_pin_oe_n;
   logic        p72_pin_o, p72_pin_oe_n, p50_pin_o, p50_pin_oe_n, p76_pin_o, p76_pin_oe_n;
   // Peripheral side
   logic        serial1_txd, serial2_txd, timer8_out_en, timer8_output;
   logic        input_a, input_b, wakeup_input_0, timer8_clock_input, timer8_reset_input;
   // Scoreboard
   logic [32:0] exp_q[$];
   int          n_errors, checked;
   ppm_byte_t   b;
   logic [31:0] v;

   ppm_port_mux dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .p17_pin_i(p17_pin_i), .p14_pin_i(p14_pin_i), .p50_pin_i(p50_pin_i), .p75_pin_i(p75_pin_i),
      .p74_pin_i(p74_pin_i), .p17_pin_o(p17_pin_o), .p17_pin_oe_n(p17_pin_oe_n), .p14_pin_o(p14_pin_o),
      .p14_pin_oe_n(p14_pin_oe_n), .p22_pin_o(p22_pin_o), .p22_pin_oe_n(p22_pin_oe_n), .p72_pin_o(p72_pin_o),
      .p72_pin_oe_n(p72_pin_oe_n), .p50_pin_o(p50_pin_o), .p50_pin_oe_n(p50_pin_oe_n), .p76_pin_o(p76_pin_o),
      .p76_pin_oe_n(p76_pin_oe_n), .serial1_txd(serial1_txd), .serial2_txd(serial2_txd),
      .timer8_out_en(timer8_out_en), .timer8_output(timer8_output), .input_a(input_a), .input_b(input_b),
      .wakeup_input_0(wakeup_input_0), .timer8_clock_input(timer8_clock_input),
      .timer8_reset_input(timer8_reset_input));

   ////////////////////////////////////////////////////////////////////////////
   // Clock generator
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   // Compare one value and count it
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Print verdict and end the run
   task automatic stop_test();
      if (n_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // One APB transfer, entered just after a rising edge; psel stays up
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready wait", 33'h0, 33'h1);
      penable <= 1'b0;
   endtask

   // Write expecting an okay answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      exp_q.push_back(33'h0);
      xfer(1'b1, a, d);
   endtask

   // Read noting the expected error flag and data
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask

   // Release the bus and let pins settle, leaving off the edge
   task automatic look();
      psel <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Answer watcher: oldest note against each completed transfer
   always @(posedge pclk) begin
      if (presetn && psel && penable && pready) begin
         if (exp_q.size() == 0) chk("unexpected answer", 33'h0, 33'h1);
         else chk("apb answer", {pslverr, prdata}, exp_q.pop_front());
      end
   end

   // Watchdog against a hung bus
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {p17_pin_i, p14_pin_i, p50_pin_i, p75_pin_i, p74_pin_i} = '0;
      {serial1_txd, serial2_txd, timer8_out_en, timer8_output} = '0;
      presetn = 1'b0;
      v = $urandom(32'h07d64a9f);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      look();
      chk("reset enables lo", {p17_pin_oe_n, p14_pin_oe_n, p22_pin_oe_n}, 3'h7);
      chk("reset enables hi", {p72_pin_oe_n, p50_pin_oe_n, p76_pin_oe_n}, 3'h7);
      chk("reset functions", {input_a, input_b, wakeup_input_0}, 3'h0);
      @(posedge pclk);
      rd(`PPM_OFF_FSEL1, 33'h0);
      // Reserved bits drop, bit 2 never set by software
      for (int i = 0; i < 5; i++) begin
         b = (i == 0) ? 8'hfb : ppm_byte_t'($urandom) & 8'hfb;
         wr(`PPM_OFF_FSEL1, {24'h0, b});
         rd(`PPM_OFF_FSEL1, {25'h0, b & `PPM_FSEL1_MASK});
      end
      rd(12'h020, {1'b1, 32'h0});
      // Peripheral functions selected
      v = $urandom;
      serial1_txd <= v[0];
      serial2_txd <= v[1];
      p17_pin_i <= 1'b1;
      p14_pin_i <= 1'b1;
      wr(`PPM_OFF_FSEL1, 32'h9a);
      look();
      chk("input_a", {input_a, p17_pin_oe_n}, 2'b11);
      chk("input_b", {input_b, p14_pin_oe_n}, 2'b11);
      chk("p72 serial", {p72_pin_o, p72_pin_oe_n}, {v[1], 1'b0});
      chk("p22 serial", {p22_pin_o, p22_pin_oe_n}, {v[0], 1'b0});
      @(posedge pclk);
      // General I/O mode on every shared pin
      wr(`PPM_OFF_FSEL1, 32'h0);
      wr(`PPM_OFF_GPIO_DIR, 32'h7);
      wr(`PPM_OFF_GPIO_OUT, {29'h0, v[4:2]});
      wr(`PPM_OFF_P7DIR, 32'h44);
      wr(`PPM_OFF_P7OUT, {25'h0, v[5], 3'h0, v[6], 2'h0});
      look();
      chk("gpio levels", {p22_pin_o, p14_pin_o, p17_pin_o}, v[4:2]);
      chk("gpio enables", {p22_pin_oe_n, p14_pin_oe_n, p17_pin_oe_n}, 3'h0);
      chk("inputs released", {input_a, input_b}, 2'b00);
      chk("p72 gpio", {p72_pin_o, p72_pin_oe_n}, {v[6], 1'b0});
      chk("p76 gpio", {p76_pin_o, p76_pin_oe_n}, {v[5], 1'b0});
      // Timer output control wins on p76
      @(posedge pclk);
      timer8_out_en <= 1'b1;
      timer8_output <= ~v[5];
      look();
      chk("p76 timer", {p76_pin_o, p76_pin_oe_n}, {~v[5], 1'b0});
      @(posedge pclk);
      // Wake-up select over the direction bit
      wr(`PPM_OFF_P5DIR, 32'h1);
      look();
      chk("p50 output", {p50_pin_o, p50_pin_oe_n}, 2'b00);
      @(posedge pclk);
      p50_pin_i <= 1'b1;
      wr(`PPM_OFF_P5SEL, 32'h1);
      look();
      chk("p50 wakeup", {p50_pin_oe_n, wakeup_input_0}, 2'b11);
      @(posedge pclk);
      // Timer inputs follow p75 and p74 whatever port 7 holds
      wr(`PPM_OFF_P7DIR, 32'hff);
      for (int i = 0; i < 3; i++) begin
         v = $urandom;
         p75_pin_i <= v[0];
         p74_pin_i <= v[1];
         look();
         chk("timer inputs", {timer8_clock_input, timer8_reset_input}, {v[0], v[1]});
         @(posedge pclk);
      end
      rd(`PPM_OFF_PIN_IN, {25'h0, 3'b111, v[0], v[1], 3'b000});
      look();
      chk("pending answers", 33'(exp_q.size()), 33'h0);
      stop_test();
   end
endmodule
